//--- core/rps_sequencer.sv
// module: reset, power-up and configuration sequencer with ahb-lite registers
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// RULE_01: watchdog runs from own rc oscillator, config-enabled
// RULE_02: hold reset until oscillator start timer expires
// RULE_03: 72 ms power-up delay on power-on only
// RULE_04: brownout forces internal reset
// RULE_05: sleep wakes on reset, watchdog or interrupt
// RULE_06: config bits: programmed reads 0
// RULE_07: config word lives at 2007h
// RULE_08: config space reachable only in programming mode
// RULE_09: config bits pick main oscillator mode
// RULE_10: bit 8 data protect, bits 12-9 zero
// RULE_11: bit 7 picks programming pin role
// RULE_12: release reset only when all holds clear
module rps_sequencer
#(
   parameter int PWRUP_CYCLES = rps_pkg::PWRUP_CYC       // power-up delay count
)
(
   input  wire logic        CORE_CLK,                    // core clock 25 MHz
   input  wire logic        SRST,                        // power-on reset, sync
   input  wire logic        HSEL,                        // ahb select
   input  wire logic [31:0] HADDR,                       // ahb address
   input  wire logic [1:0]  HTRANS,                      // ahb transfer type
   input  wire logic        HWRITE,                      // ahb write
   input  wire logic [2:0]  HSIZE,                       // ahb size
   input  wire logic [31:0] HWDATA,                      // ahb write data
   input  wire logic        HREADY,                      // ahb bus ready
   output logic [31:0]      HRDATA,                      // ahb read data
   output logic             HREADYOUT,                   // ahb slave ready
   output logic             HRESP,                       // ahb response
   input  wire logic [13:0] CFG_NV,                      // stored config word
   input  wire logic        BROWNOUT_DET,                // supply below trip
   input  wire logic        MASTER_CLEAR_PIN_N,          // external reset pin
   input  wire logic        PROG_MODE_INPUT,             // low-voltage prog pin
   input  wire logic        HV_PROG_DET,                 // high voltage on reset pin
   input  wire logic        IRQ,                         // pending interrupt
   input  wire logic        WDOG_RC_TICK,                // rc oscillator tick
   output logic             CPU_RESET,                   // core held in reset
   output logic             SLEEPING,                    // core asleep
   output logic             OSC_ENABLE,                  // main oscillator on
   output rps_pkg::rps_osc_t OSC_MODE,                   // chosen oscillator
   output logic             PROG_PIN_IS_IO,              // shared pin is plain i/o
   output logic             DATA_MEM_PROTECT,            // data memory protected
   output logic             PROG_MEM_PROTECT,            // program memory protected
   output logic             CFG_PROG_WE,                 // write config to nv
   output logic [13:0]      CFG_PROG_DATA                // config word to nv
);
   import rps_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // oscillator mode from select bits
   function automatic rps_osc_t osc_decode(input logic [13:0] c);
      logic [2:0] s;
      s = {c[CFG_OSEL2], c[CFG_OSEL1], c[CFG_OSEL0]};
      unique case (s)
         3'h0:    osc_decode = OSC_LOWPWR;
         3'h1:    osc_decode = OSC_XTAL;
         3'h2:    osc_decode = OSC_HSPEED;
         3'h3:    osc_decode = OSC_EXTCLK;
         default: osc_decode = OSC_RCOSC;
      endcase
   endfunction

   // plain register select from a byte address
   function automatic rps_sel_t reg_decode(input logic [15:0] a);
      if (a == A_STATUS)       reg_decode = SEL_STATUS;
      else if (a == A_CONTROL) reg_decode = SEL_CONTROL;
      else if (a == A_CAUSE)   reg_decode = SEL_CAUSE;
      else                     reg_decode = SEL_NONE;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   rps_wdog_if  wd ();                                   // watchdog link
   logic [13:0] cfg_reg;                                 // live config word
   logic        cfg_ld_reg;                              // config loaded
   logic [20:0] pwr_cnt_reg;                             // power-up delay count
   logic        pwr_done_reg;                            // power-up delay over
   logic [10:0] settle_cnt_reg;                          // oscillator settle count
   logic        settle_done_reg;                         // oscillator stable
   logic        wrst_reg;                                // watchdog reset pulse
   logic [4:0]  cause_reg;                               // reset cause flags
   rps_state_t  state_reg;                               // run / sleep
   logic        dp_wr_reg;                               // write data phase
   logic [15:0] dp_addr_reg;                             // data phase address
   logic [31:0] rdata_reg;                               // read data
   logic        aphase;                                  // valid address phase
   logic        cfg_addr;                                // address in config space
   logic        prog_mode;                               // programming mode
   logic        bo_active;                               // brownout hold
   logic        mc_active;                               // master clear hold
   logic        hold_any;                                // any reset source
   logic        xtal;                                    // crystal needs settle
   logic        wake;                                    // sleep exit, no reset
   logic        ctl_wr;                                  // control write strobe
   logic        cfg_wr;                                  // config write strobe

   // ----------------------------------------------------------------
   // config decode
   // ----------------------------------------------------------------
   // protect and power-up delay bits are active when programmed, i.e. 0  [RULE_06]
   assign prog_mode = cfg_reg[CFG_LVPE] ? PROG_MODE_INPUT : HV_PROG_DET; // [RULE_11]
   assign PROG_PIN_IS_IO   = !cfg_reg[CFG_LVPE];         // [RULE_11]
   assign DATA_MEM_PROTECT = !cfg_reg[CFG_DMP];          // [RULE_10]
   assign PROG_MEM_PROTECT = !cfg_reg[CFG_PMP];          // [RULE_06]
   assign OSC_MODE  = osc_decode(cfg_reg);               // [RULE_09]
   assign xtal      = (osc_decode(cfg_reg) == OSC_LOWPWR) || (osc_decode(cfg_reg) == OSC_XTAL) ||
                      (osc_decode(cfg_reg) == OSC_HSPEED);
   assign bo_active = cfg_reg[CFG_BOEN] && BROWNOUT_DET; // [RULE_04]
   assign mc_active = cfg_reg[CFG_MCE] && !MASTER_CLEAR_PIN_N;
   // every source must be gone before the core runs  [RULE_12]
   assign hold_any  = !cfg_ld_reg || !pwr_done_reg || !settle_done_reg || bo_active ||
                      mc_active || wrst_reg || prog_mode;
   assign CPU_RESET = hold_any;
   assign wake      = (state_reg == ST_SLEEP) && (IRQ || wd.timeout); // [RULE_05]

   // config load at release, then programming writes only  [RULE_07]
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         cfg_reg    <= CFG_ERASED;
         cfg_ld_reg <= 1'b0;
      end
      else if (!cfg_ld_reg)
      begin
         cfg_reg    <= CFG_NV & CFG_MASK;                // [RULE_10]
         cfg_ld_reg <= 1'b1;
      end
      else if (cfg_wr)
         cfg_reg <= HWDATA[13:0] & CFG_MASK;
   end

   // ----------------------------------------------------------------
   // hold timers
   // ----------------------------------------------------------------
   // power-up delay: runs once after power-on, brownout never restarts it
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         pwr_cnt_reg  <= 21'h000000;
         pwr_done_reg <= 1'b0;
      end
      else if (cfg_ld_reg && !pwr_done_reg)
      begin
         if (cfg_reg[CFG_PUDE] || pwr_cnt_reg == 21'(PWRUP_CYCLES - 1)) // [RULE_03]
            pwr_done_reg <= 1'b1;
         else
            pwr_cnt_reg <= pwr_cnt_reg + 21'h000001;
      end
   end

   // oscillator settle: after power-up, brownout and wake from sleep
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST || bo_active || wake)
      begin
         settle_cnt_reg  <= 11'h000;
         settle_done_reg <= 1'b0;                        // [RULE_02]
      end
      else if (pwr_done_reg && !settle_done_reg)
      begin
         if (!xtal || settle_cnt_reg == 11'(OSC_START_CYC - 1))
            settle_done_reg <= 1'b1;                     // [RULE_02]
         else
            settle_cnt_reg <= settle_cnt_reg + 11'h001;
      end
   end

   // ----------------------------------------------------------------
   // watchdog and sleep
   // ----------------------------------------------------------------
   assign wd.enable  = cfg_reg[CFG_WDE] && cfg_ld_reg;   // [RULE_01]
   assign wd.clear   = hold_any || (ctl_wr && HWDATA[CTL_WCLR]) ||
                       (ctl_wr && HWDATA[CTL_SLEEP]);
   assign wd.rc_tick = WDOG_RC_TICK;                     // [RULE_01]

   rps_watchdog u_wdog
   (
      .clk  (CORE_CLK),
      .srst (SRST),
      .wd   (wd)
   );

   // awake expiry resets the core for one cycle
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         wrst_reg <= 1'b0;
      else
         wrst_reg <= wd.timeout && (state_reg == ST_RUN);
   end

   // sleep entry by software; leaves on reset or wake event
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         state_reg <= ST_RUN;
      else
         unique case (state_reg)
            ST_RUN:
               if (ctl_wr && HWDATA[CTL_SLEEP] && !hold_any)
                  state_reg <= ST_SLEEP;
            ST_SLEEP:
               if (hold_any || wake)                     // [RULE_05]
                  state_reg <= ST_RUN;
         endcase
   end
   assign SLEEPING   = (state_reg == ST_SLEEP);
   // oscillator stops in sleep, except in rc and external clock modes
   assign OSC_ENABLE = (state_reg == ST_RUN) || !xtal;

   // reset cause flags, write one to clear, a new cause wins
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         cause_reg <= 5'h01;
      else
      begin
         for (int i = 0; i < 5; i++)
            if (!dp_wr_reg || reg_decode(dp_addr_reg) != SEL_CAUSE || !HWDATA[i]) ;
            else cause_reg[i] <= 1'b0;
         if (bo_active) cause_reg[CS_BROWN] <= 1'b1;     // [RULE_04]
         if (wrst_reg)  cause_reg[CS_WDOG]  <= 1'b1;
         if (mc_active) cause_reg[CS_EXTRST] <= 1'b1;
         if (wake && wd.timeout) cause_reg[CS_WAKE] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------------------------------
   assign aphase    = HSEL && HTRANS[1] && HREADY;
   assign cfg_addr  = dp_addr_reg[15];                   // index 2000h-3FFFh
   assign ctl_wr    = dp_wr_reg && reg_decode(dp_addr_reg) == SEL_CONTROL;
   // config space closed outside programming mode  [RULE_08]
   assign cfg_wr    = dp_wr_reg && cfg_addr && prog_mode &&
                      dp_addr_reg[15:2] == CFG_LOC;      // [RULE_07]
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_reg;
   assign CFG_PROG_WE   = cfg_wr;
   assign CFG_PROG_DATA = cfg_reg;

   // capture address phase
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 16'h0000;
      end
      else
      begin
         dp_wr_reg   <= aphase && HWRITE;
         dp_addr_reg <= aphase ? HADDR[15:0] : dp_addr_reg;
      end
   end

   // read data staged in the address phase
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         rdata_reg <= 32'h00000000;
      else if (aphase && !HWRITE)
      begin
         if (HADDR[15])                                  // [RULE_08]
            rdata_reg <= (prog_mode && HADDR[15:2] == CFG_LOC) ? {18'h00000, cfg_reg} : 32'h0;
         else
            unique case (reg_decode(HADDR[15:0]))
               SEL_STATUS:  rdata_reg <= {26'h0, prog_mode, SLEEPING, hold_any,
                                          settle_done_reg, pwr_done_reg, cfg_ld_reg};
               SEL_CAUSE:   rdata_reg <= {27'h0, cause_reg};
               SEL_CONTROL: rdata_reg <= 32'h00000000;
               SEL_NONE:    rdata_reg <= 32'h00000000;
            endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pwrup_holds: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_03]
      !pwr_done_reg |-> CPU_RESET)
      else $error("core ran during power-up delay");
   a_pwrup_once: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_03]
      pwr_done_reg |=> pwr_done_reg)
      else $error("power-up delay restarted without power-on");
   a_osc_restart: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_02]
      bo_active |=> !settle_done_reg ##0 CPU_RESET)
      else $error("oscillator settle not restarted");
   a_brown_reset: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_04]
      (cfg_reg[CFG_BOEN] && BROWNOUT_DET) |-> CPU_RESET)
      else $error("brownout did not reset core");
   a_irq_wake: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_05]
      (SLEEPING && IRQ) |=> !SLEEPING)
      else $error("interrupt did not wake core");
   a_mc_polarity: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_06]
      (cfg_reg[CFG_MCE] && !MASTER_CLEAR_PIN_N) |-> CPU_RESET)
      else $error("enabled master clear pin did not hold core");
   a_cfg_locked: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_08]
      (cfg_ld_reg && !prog_mode) |=> $stable(cfg_reg))
      else $error("config changed outside programming mode");
   a_cfg_unimpl: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_10]
      cfg_reg[12:9] == 4'h0)
      else $error("unimplemented config bits set");
   a_pin_role: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_11]
      (PROG_PIN_IS_IO ? HV_PROG_DET : PROG_MODE_INPUT) |-> CPU_RESET)
      else $error("programming entry on chosen pin did not hold core");
   a_release_all: assert property (@(posedge CORE_CLK) disable iff (SRST) // [RULE_12]
      $fell(CPU_RESET) |-> pwr_done_reg && settle_done_reg && !bo_active && !mc_active)
      else $error("reset released with a hold active");
   c_irq_wake:  cover property (@(posedge CORE_CLK) disable iff (SRST) SLEEPING ##1 !SLEEPING);
   c_wdog_rst:  cover property (@(posedge CORE_CLK) disable iff (SRST) wrst_reg);
   c_cfg_write: cover property (@(posedge CORE_CLK) disable iff (SRST) cfg_wr);
endmodule

//--- core/rps_pkg.sv
// package: constants, config word layout and types of the reset/power sequencer
package rps_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ       = 25_000_000;             // core clock rate
   localparam int T_PWRUP_MS   = 72;                     // power-up delay, ms
   localparam int PWRUP_CYC    = T_PWRUP_MS * (CLK_HZ / 1000); // 1.8M cycles
   localparam int OSC_START_CYC = 1024;                  // oscillator settle count
   localparam int WDOG_TICKS   = 18;                     // rc ticks to timeout

   // ----------------------------------------------------------------
   // register map (byte addresses, low 16 bits of haddr)
   // ----------------------------------------------------------------
   localparam logic [15:0] A_STATUS  = 16'h0000;         // live state, read only
   localparam logic [15:0] A_CONTROL = 16'h0004;         // sleep / watchdog clear
   localparam logic [15:0] A_CAUSE   = 16'h0008;         // reset causes, w1c
   localparam logic [13:0] CFG_LOC   = 14'h2007;         // config word location
   localparam logic [13:0] CFG_LO    = 14'h2000;         // config space start
   localparam logic [13:0] CFG_HI    = 14'h3FFF;         // config space end

   // ----------------------------------------------------------------
   // config word fields (0 = programmed, 1 = erased)
   // ----------------------------------------------------------------
   localparam int CFG_PMP    = 13;                       // program mem protect
   localparam int CFG_DMP    = 8;                        // data mem protect
   localparam int CFG_LVPE   = 7;                        // low-voltage prog enable
   localparam int CFG_BOEN   = 6;                        // brownout detect enable
   localparam int CFG_MCE    = 5;                        // master clear pin enable
   localparam int CFG_OSEL2  = 4;                        // oscillator select 2
   localparam int CFG_PUDE   = 3;                        // power-up delay enable
   localparam int CFG_WDE    = 2;                        // watchdog enable
   localparam int CFG_OSEL1  = 1;                        // oscillator select 1
   localparam int CFG_OSEL0  = 0;                        // oscillator select 0
   localparam logic [13:0] CFG_MASK   = 14'h21FF;        // implemented bits
   localparam logic [13:0] CFG_ERASED = 14'h21FF;        // all unprogrammed

   // ----------------------------------------------------------------
   // control / cause / status bits
   // ----------------------------------------------------------------
   localparam int CTL_SLEEP = 0;                         // enter sleep
   localparam int CTL_WCLR  = 1;                         // clear watchdog
   localparam int CS_PWRON  = 0;                         // power-on seen
   localparam int CS_BROWN  = 1;                         // brownout reset seen
   localparam int CS_WDOG   = 2;                         // watchdog reset seen
   localparam int CS_EXTRST = 3;                         // master clear seen
   localparam int CS_WAKE   = 4;                         // watchdog wake seen

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {OSC_LOWPWR, OSC_XTAL, OSC_HSPEED, OSC_EXTCLK,
                             OSC_RCOSC} rps_osc_t;        // main oscillator modes
   typedef enum {ST_RUN, ST_SLEEP} rps_state_t;          // core power state
   typedef enum logic [1:0] {SEL_NONE, SEL_STATUS, SEL_CONTROL,
                             SEL_CAUSE} rps_sel_t;        // plain register select
endpackage

//--- core/rps_wdog_if.sv
// interface: sequencer to watchdog timer link
`timescale 1ns/1ps
interface rps_wdog_if;
   logic       enable;                                   // watchdog running
   logic       clear;                                    // restart count
   logic       rc_tick;                                  // dedicated rc oscillator tick
   logic       timeout;                                  // one-cycle expiry pulse
   logic [7:0] count;                                    // current tick count
   modport seq  (output enable, clear, rc_tick, input timeout, count);
   modport wdog (input enable, clear, rc_tick, output timeout, count);
endinterface

//--- core/rps_watchdog.sv
// module: watchdog timer counting ticks of its own rc oscillator
`timescale 1ns/1ps
module rps_watchdog
(
   input  wire logic     clk,                            // core clock
   input  wire logic     srst,                           // sync reset
   rps_wdog_if.wdog      wd                              // link to sequencer
);
   import rps_pkg::*;

   // ----------------------------------------------------------------
   // tick counter
   // ----------------------------------------------------------------
   logic [7:0] cnt_reg;                                  // rc ticks seen
   logic       tmo_reg;                                  // expiry pulse
   logic       at_end;                                   // last tick reached

   assign at_end     = (cnt_reg == 8'(WDOG_TICKS - 1));
   assign wd.count   = cnt_reg;
   assign wd.timeout = tmo_reg;

   // counts only on rc ticks, never on core edges alone
   always_ff @(posedge clk)
   begin
      if (srst || !wd.enable || wd.clear)
         cnt_reg <= 8'h00;
      else if (wd.rc_tick)                               // [RULE_01]
         cnt_reg <= at_end ? 8'h00 : cnt_reg + 8'h01;
   end

   // expiry pulse, one cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         tmo_reg <= 1'b0;
      else
         tmo_reg <= wd.enable && !wd.clear && wd.rc_tick && at_end;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_wdog_wraps: assert property (@(posedge clk) disable iff (srst) // [RULE_01]
      tmo_reg |-> cnt_reg == 8'h00)
      else $error("watchdog count did not wrap on timeout");
   a_wdog_off_quiet: assert property (@(posedge clk) disable iff (srst) // [RULE_01]
      !wd.enable |=> !tmo_reg)
      else $error("disabled watchdog timed out");
endmodule

//--- bench/rps_far_model.sv
// model: supply monitor, reset pin and watchdog rc oscillator
`timescale 1ns/1ps
module rps_far_model
(
   input  wire logic clk,                // core clock
   input  wire logic brown_req,          // bench asks for a dip
   input  wire logic pin_req,            // bench presses reset
   output logic      brown_det = 1'b0,   // supply below trip
   output logic      rst_pin_n = 1'b1,   // reset pin, pulled up
   output logic      rc_tick = 1'b0      // rc oscillator tick
);
   logic [2:0] div = 3'h0;               // rc period in core cycles
   // free-running rc tick, modelled as the core clock divided by 8
   always @(posedge clk)
   begin
      div <= div + 3'h1;
      rc_tick <= (div == 3'h7);
      brown_det <= brown_req;
      rst_pin_n <= ~pin_req;
   end
endmodule

//--- bench/tb_reset_power_config_sequencer.sv
// testbench: reset, power-up and config sequencer
`timescale 1ns/1ps
module tb_reset_power_config_sequencer;
   import rps_pkg::*;
   localparam int PU = 50;                 // short power-up delay
   logic clk = 0, srst = 1, hsel = 0, hwrite = 0, irq = 0, prog_in = 0, hv = 0, brq = 0, mrq = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [13:0] cfg = CFG_ERASED, cfg_data;
   logic hrdy, hresp, bod, mcn, tick, cpu_rst, slp, osc_en, pin_io, dmp, pmp, cfg_we;
   rps_osc_t osc;                          // decoded oscillator mode
   int miscompares = 0, comparisons = 0, cyc = 0, we_cnt = 0;
   // rows: {config word, mode, shared pin io, data protect, program protect}
   logic [19:0] rows [6] = '{{14'h21FF, 3'h4, 3'b000}, {14'h2000, 3'h0, 3'b110},
      {14'h2003, 3'h3, 3'b110}, {14'h2181, 3'h1, 3'b000}, {14'h2012, 3'h4, 3'b110},
      {14'h0102, 3'h2, 3'b101}};
   rps_sequencer #(.PWRUP_CYCLES(PU)) u_dut (.CORE_CLK(clk), .SRST(srst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .CFG_NV(cfg),
      .BROWNOUT_DET(bod), .MASTER_CLEAR_PIN_N(mcn), .PROG_MODE_INPUT(prog_in), .HV_PROG_DET(hv),
      .IRQ(irq), .WDOG_RC_TICK(tick), .CPU_RESET(cpu_rst), .SLEEPING(slp), .OSC_ENABLE(osc_en),
      .OSC_MODE(osc), .PROG_PIN_IS_IO(pin_io), .DATA_MEM_PROTECT(dmp),
      .PROG_MEM_PROTECT(pmp), .CFG_PROG_WE(cfg_we), .CFG_PROG_DATA(cfg_data));
   rps_far_model u_far (.clk(clk), .brown_req(brq), .pin_req(mrq), .brown_det(bod),
      .rst_pin_n(mcn), .rc_tick(tick));
   initial forever #20 clk = ~clk;
   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single word transfer, address phase then data phase
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
      chk(hresp, 1'b0);
   endtask
   // bounded wait for the core reset to reach a level
   task automatic wait_rst(input logic v, input int n);
      repeat (n) if (cpu_rst !== v) @(posedge clk);
      chk(cpu_rst, v);
   endtask
   task automatic rst(input logic [13:0] c);
      @(posedge clk);
      srst <= 1'b1;
      cfg <= c;
      repeat (12) @(posedge clk);
      chk(cpu_rst, 1'b1);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cfg_we) we_cnt++;                        // config write pulses seen
      if (cyc == 3000)
      begin
         miscompares++;
         stop_test;
      end
   end
   initial
   begin
      foreach (rows[i])
      begin
         rst(rows[i][19:6]);
         chk(osc, rows[i][5:3]);
         chk({pin_io, dmp, pmp}, rows[i][2:0]);
      end
      rst(14'h2163);
      repeat (PU - 10) @(posedge clk);
      chk(cpu_rst, 1'b1);
      wait_rst(1'b0, 20);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h7);
      bus(1'b0, 32'h801C, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 32'h801C, 32'h0);
      chk(cfg_data, 14'h2163);
      chk(we_cnt, 0);
      hv <= 1'b1;
      wait_rst(1'b1, 3);
      hv <= 1'b0;
      wait_rst(1'b0, 5);
      prog_in <= 1'b1;
      repeat (2) @(posedge clk);
      chk(cpu_rst, 1'b0);
      prog_in <= 1'b0;
      brq <= 1'b1;
      wait_rst(1'b1, 5);
      brq <= 1'b0;
      wait_rst(1'b0, 10);
      mrq <= 1'b1;
      wait_rst(1'b1, 5);
      mrq <= 1'b0;
      wait_rst(1'b0, 10);
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, 32'hB);
      bus(1'b1, 32'h8, 32'hB);
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 32'h4, 32'h1);
      @(posedge clk);
      chk(slp, 1'b1);
      chk(osc_en, 1'b1);
      irq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(slp, 1'b0);
      irq <= 1'b0;
      rst(14'h2167);
      wait_rst(1'b0, 60);
      wait_rst(1'b1, 200);
      wait_rst(1'b0, 5);
      bus(1'b1, 32'h4, 32'h1);
      @(posedge clk);
      chk(slp, 1'b1);
      repeat (200) if (slp !== 1'b0) @(posedge clk);
      chk(slp, 1'b0);
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h15);
      prog_in <= 1'b1;
      rst(14'h3FFF);
      bus(1'b0, 32'h801C, 32'h0);
      chk(rd, 32'h21FF);
      bus(1'b1, 32'h801C, 32'h3F7B);
      @(posedge clk);
      chk(cfg_data, 14'h217B);
      chk(we_cnt, 1);
      stop_test;
   end
endmodule
